/* logic/tsq_pkg.sv */
// Package for the TMS path sequencer: TAP state codes and reset values
//------------------------------------------------------------
//------------------------------------------------------------
package tsq_pkg;

    localparam int STATE_W = 4;

    typedef enum logic [STATE_W-1:0] {
        tsq_reset_state,
        tsq_idle_state,
        tsq_select_data_scan_state,
        tsq_capture_dr_state,
        tsq_shift_dr_state,
        tsq_exit1_dr_state,
        tsq_pause_dr_state,
        tsq_exit2_dr_state,
        tsq_update_dr_state,
        tsq_select_instr_scan_state,
        tsq_capture_ir_state,
        tsq_shift_ir_state,
        tsq_exit1_ir_state,
        tsq_pause_ir_state,
        tsq_exit2_ir_state,
        tsq_update_ir_state
    } tsq_state_e;

    localparam tsq_state_e STATE_RESET_VAL = tsq_reset_state;
    localparam logic TMS_RESET_VAL = 1'b1;
    localparam logic SYNC_RESET_VAL = 1'b0;

endpackage

/* logic/tsq_tap_step.sv */
// Next-state function of the standard sixteen-state TAP controller
`timescale 1ns/1ps
module tsq_tap_step (
    // Present state and sampled TMS
    input wire tsq_pkg::tsq_state_e cur_state,
    input wire logic tms,
    // Following state
    output tsq_pkg::tsq_state_e nxt_state
);
    import tsq_pkg::*;

    always_comb begin
        case (cur_state)
            tsq_reset_state: nxt_state = tms ? tsq_reset_state : tsq_idle_state;
            tsq_idle_state: nxt_state = tms ? tsq_select_data_scan_state : tsq_idle_state;
            tsq_select_data_scan_state: nxt_state = tms ? tsq_select_instr_scan_state : tsq_capture_dr_state;
            tsq_capture_dr_state: nxt_state = tms ? tsq_exit1_dr_state : tsq_shift_dr_state;
            tsq_shift_dr_state: nxt_state = tms ? tsq_exit1_dr_state : tsq_shift_dr_state;
            tsq_exit1_dr_state: nxt_state = tms ? tsq_update_dr_state : tsq_pause_dr_state;
            tsq_pause_dr_state: nxt_state = tms ? tsq_exit2_dr_state : tsq_pause_dr_state;
            tsq_exit2_dr_state: nxt_state = tms ? tsq_update_dr_state : tsq_shift_dr_state;
            tsq_update_dr_state: nxt_state = tms ? tsq_select_data_scan_state : tsq_idle_state;
            tsq_select_instr_scan_state: nxt_state = tms ? tsq_reset_state : tsq_capture_ir_state;
            tsq_capture_ir_state: nxt_state = tms ? tsq_exit1_ir_state : tsq_shift_ir_state;
            tsq_shift_ir_state: nxt_state = tms ? tsq_exit1_ir_state : tsq_shift_ir_state;
            tsq_exit1_ir_state: nxt_state = tms ? tsq_update_ir_state : tsq_pause_ir_state;
            tsq_pause_ir_state: nxt_state = tms ? tsq_exit2_ir_state : tsq_pause_ir_state;
            tsq_exit2_ir_state: nxt_state = tms ? tsq_update_ir_state : tsq_shift_ir_state;
            tsq_update_ir_state: nxt_state = tms ? tsq_select_data_scan_state : tsq_idle_state;
            default: nxt_state = tsq_reset_state;
        endcase
    end

endmodule

/* logic/tsq_path_sequencer.sv */
// TMS path sequencer: walks the target TAP controllers to a requested end state
`timescale 1ns/1ps
module tsq_path_sequencer (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Test clock as seen on the link
    input wire logic tck,
    // End-state request from command logic
    input wire logic req_valid,
    input wire tsq_pkg::tsq_state_e req_end_state,
    // Scan buffer stall and clock mode
    input wire logic buf_stall,
    input wire logic gated_mode,
    // Link and status
    output logic tms,
    output logic [tsq_pkg::STATE_W-1:0] current_tap_state_field,
    output logic busy
);
    import tsq_pkg::*;

    //------------------------------------------------------------
    // TCK synchroniser and edge detect
    //------------------------------------------------------------
    logic tck_s1_ff;
    logic tck_s2_ff;
    logic tck_s3_ff;
    logic tck_fall;
    logic tck_rise;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            tck_s1_ff <= SYNC_RESET_VAL;
            tck_s2_ff <= SYNC_RESET_VAL;
            tck_s3_ff <= SYNC_RESET_VAL;
        end else begin
            tck_s1_ff <= tck;
            tck_s2_ff <= tck_s1_ff;
            tck_s3_ff <= tck_s2_ff;
        end
    end

    assign tck_fall = tck_s3_ff & ~tck_s2_ff;
    assign tck_rise = ~tck_s3_ff & tck_s2_ff;

    //------------------------------------------------------------
    // Requested end state and recapture flag
    //------------------------------------------------------------
    tsq_state_e end_state_ff;
    tsq_state_e state_ff;
    tsq_state_e nxt_state;
    tsq_state_e goal;
    logic leave_ff;
    logic tms_ff;
    logic nxt_tms;
    logic at_pause;

    assign at_pause = (state_ff == tsq_pause_dr_state) || (state_ff == tsq_pause_ir_state);

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            end_state_ff <= STATE_RESET_VAL;
        end else if (req_valid) begin
            end_state_ff <= req_end_state;
        end
    end

    // Asking for the pause state already held forces a fresh capture pass
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            leave_ff <= 1'b0;
        end else if (req_valid && req_end_state == state_ff && at_pause) begin
            leave_ff <= 1'b1;
        end else if (tck_rise && state_ff != nxt_state) begin
            leave_ff <= 1'b0;
        end
    end

    // Free-running stall parks the scan in the matching pause state
    always_comb begin
        goal = end_state_ff;
        if (buf_stall && !gated_mode && end_state_ff == tsq_shift_dr_state) begin
            goal = tsq_pause_dr_state;
        end else if (buf_stall && !gated_mode && end_state_ff == tsq_shift_ir_state) begin
            goal = tsq_pause_ir_state;
        end
    end

    //------------------------------------------------------------
    // Shortest-path TMS choice
    //------------------------------------------------------------
    always_comb begin
        case (state_ff)
            tsq_reset_state: nxt_tms = (goal == tsq_reset_state);
            tsq_idle_state: nxt_tms = (goal != tsq_idle_state);
            tsq_select_data_scan_state:
                nxt_tms = !(goal == tsq_shift_dr_state || goal == tsq_pause_dr_state);
            tsq_select_instr_scan_state:
                nxt_tms = !(goal == tsq_shift_ir_state || goal == tsq_pause_ir_state);
            tsq_capture_dr_state: nxt_tms = (goal != tsq_shift_dr_state);
            tsq_capture_ir_state: nxt_tms = (goal != tsq_shift_ir_state);
            tsq_shift_dr_state: nxt_tms = (goal != tsq_shift_dr_state);
            tsq_shift_ir_state: nxt_tms = (goal != tsq_shift_ir_state);
            tsq_exit1_dr_state: nxt_tms = (goal != tsq_pause_dr_state);
            tsq_exit1_ir_state: nxt_tms = (goal != tsq_pause_ir_state);
            tsq_pause_dr_state: nxt_tms = leave_ff || (goal != tsq_pause_dr_state);
            tsq_pause_ir_state: nxt_tms = leave_ff || (goal != tsq_pause_ir_state);
            tsq_exit2_dr_state: nxt_tms = (goal != tsq_shift_dr_state);
            tsq_exit2_ir_state: nxt_tms = (goal != tsq_shift_ir_state);
            tsq_update_dr_state: nxt_tms = (goal != tsq_idle_state);
            tsq_update_ir_state: nxt_tms = (goal != tsq_idle_state);
            default: nxt_tms = 1'b1;
        endcase
    end

    // TMS moves only on the falling test clock edge
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            tms_ff <= TMS_RESET_VAL;
        end else if (tck_fall) begin
            tms_ff <= nxt_tms;
        end
    end

    //------------------------------------------------------------
    // Mirror of the target controllers
    //------------------------------------------------------------
    tsq_tap_step u_step (
        .cur_state(state_ff),
        .tms(tms_ff),
        .nxt_state(nxt_state)
    );

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_ff <= STATE_RESET_VAL;
        end else if (tck_rise) begin
            state_ff <= nxt_state;
        end
    end

    assign tms = tms_ff;
    assign current_tap_state_field = state_ff;
    assign busy = leave_ff || (state_ff != goal);

    //------------------------------------------------------------
    // Checks
    //------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    a_tms_fall_only: assert property (!tck_fall |=> $stable(tms))
        else $error("TMS changed away from a falling TCK edge");
    a_state_rise_only: assert property (!tck_rise |=> $stable(current_tap_state_field))
        else $error("TAP state changed away from a rising TCK edge");
    a_idle_hold_low: assert property (tck_fall && state_ff == tsq_idle_state
        && goal == tsq_idle_state |=> !tms)
        else $error("Idle not held with TMS low");
    a_idle_leave_high: assert property (tck_fall && state_ff == tsq_idle_state
        && goal == tsq_reset_state |=> tms)
        else $error("Idle to reset did not start high");
    a_reset_hold_high: assert property (tck_fall && state_ff == tsq_reset_state
        && goal == tsq_reset_state |=> tms)
        else $error("Reset not held with TMS high");
    a_exit2_resume: assert property (tck_fall && state_ff == tsq_exit2_dr_state
        && goal == tsq_shift_dr_state |=> !tms)
        else $error("Exit2-DR did not resume shift");
    a_recapture_leave: assert property (tck_fall && state_ff == tsq_pause_dr_state
        && leave_ff |=> tms)
        else $error("Recapture did not leave pause");
    a_upd_ir_idle: assert property (tck_fall && state_ff == tsq_update_ir_state
        && goal == tsq_idle_state |=> !tms)
        else $error("Update-IR to idle not low");
    a_seldr_capture: assert property (tck_fall && state_ff == tsq_select_data_scan_state
        && goal == tsq_shift_dr_state |=> !tms)
        else $error("Select-DR did not enter capture");
    a_shift_dr_exit: assert property (tck_fall && state_ff == tsq_shift_dr_state
        && goal != tsq_shift_dr_state |=> tms)
        else $error("Shift-DR not exited with TMS high");
    a_selir_capture: assert property (tck_fall && state_ff == tsq_select_instr_scan_state
        && goal == tsq_pause_ir_state |=> !tms)
        else $error("Select-IR did not enter capture");
    a_exit1_ir_pause: assert property (tck_fall && state_ff == tsq_exit1_ir_state
        && goal == tsq_pause_ir_state |=> !tms)
        else $error("Exit1-IR did not pause");
    a_gated_stall_hold: assert property (buf_stall && gated_mode && tck_fall
        && state_ff == tsq_shift_dr_state && end_state_ff == tsq_shift_dr_state |=> !tms)
        else $error("Gated stall left shift state");

    c_reach_shift_dr: cover property (state_ff == tsq_idle_state ##[1:400] state_ff == tsq_shift_dr_state);
    c_stall_pause: cover property (buf_stall && !gated_mode && state_ff == tsq_pause_dr_state);
    c_recapture: cover property ((leave_ff && state_ff == tsq_pause_ir_state) ##[1:400]
        state_ff == tsq_capture_ir_state);
    c_reset_route: cover property (state_ff == tsq_shift_ir_state ##[1:400] state_ff == tsq_reset_state);

endmodule

/* testbench/tsq_tap_target.sv */
// Behavioural target TAP controller driven by the sequencer's link
`timescale 1ns/1ps
module tsq_tap_target (
    // Link from the sequencer
    input wire logic tck,
    input wire logic tms,
    // Controller state
    output tsq_pkg::tsq_state_e state
);
    import tsq_pkg::*;
    initial state = tsq_reset_state;
    always @(posedge tck) begin
        case (state)
            tsq_reset_state: state <= tms ? tsq_reset_state : tsq_idle_state;
            tsq_idle_state: state <= tms ? tsq_select_data_scan_state : tsq_idle_state;
            tsq_select_data_scan_state: state <= tms ? tsq_select_instr_scan_state : tsq_capture_dr_state;
            tsq_capture_dr_state, tsq_shift_dr_state: state <= tms ? tsq_exit1_dr_state : tsq_shift_dr_state;
            tsq_exit1_dr_state: state <= tms ? tsq_update_dr_state : tsq_pause_dr_state;
            tsq_pause_dr_state: state <= tms ? tsq_exit2_dr_state : tsq_pause_dr_state;
            tsq_exit2_dr_state: state <= tms ? tsq_update_dr_state : tsq_shift_dr_state;
            tsq_select_instr_scan_state: state <= tms ? tsq_reset_state : tsq_capture_ir_state;
            tsq_capture_ir_state, tsq_shift_ir_state: state <= tms ? tsq_exit1_ir_state : tsq_shift_ir_state;
            tsq_exit1_ir_state: state <= tms ? tsq_update_ir_state : tsq_pause_ir_state;
            tsq_pause_ir_state: state <= tms ? tsq_exit2_ir_state : tsq_pause_ir_state;
            tsq_exit2_ir_state: state <= tms ? tsq_update_ir_state : tsq_shift_ir_state;
            default: state <= tms ? tsq_select_data_scan_state : tsq_idle_state;
        endcase
    end
endmodule

/* testbench/testbench.sv */
// Self-checking bench: sequencer routes checked against a target TAP model
`timescale 1ns/1ps
module testbench;
    import tsq_pkg::*;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic tck = 1'b0;
    logic req_valid = 1'b0;
    tsq_state_e req_end_state = tsq_reset_state;
    logic buf_stall = 1'b0;
    logic gated_mode = 1'b0;
    logic tms;
    logic busy;
    logic rec = 1'b0;
    logic [3:0] current_tap_state_field;
    tsq_state_e tgt_state;
    logic [16:0] lfsr = 17'h13D7F;
    logic tq[$];
    int n_mismatch = 0;
    int checks_done = 0;

    initial forever #50 core_clk = ~core_clk;
    // Link clock, phase unrelated to the core clock
    initial begin
        #37;
        forever #400 tck = ~tck;
    end
    always @(posedge tck) if (rec) tq.push_back(tms);

    tsq_path_sequencer dut (.core_clk(core_clk), .sys_rst(sys_rst), .tck(tck), .req_valid(req_valid),
        .req_end_state(req_end_state), .buf_stall(buf_stall), .gated_mode(gated_mode), .tms(tms),
        .current_tap_state_field(current_tap_state_field), .busy(busy));
    tsq_tap_target target (.tck(tck), .tms(tms), .state(tgt_state));

    // Seventeen-bit maximal-length shift register step
    function automatic logic [16:0] lfsr_next(input logic [16:0] v);
        return {v[15:0], v[16] ^ v[13]};
    endfunction

    task final_report;
        $display("Checks: %0d, mismatches: %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task chk(input logic [3:0] seen, input logic [3:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task timeout;
        n_mismatch++;
        $display("MISMATCH %0t wait ran out", $time);
        final_report();
    endtask

    // Request an end state; tail of the TMS record must match, earlier cycles hold the stay level
    task run(input tsq_state_e e, input int len, input logic [6:0] bits);
        int i;
        int off;
        logic stay;
        stay = (tgt_state == tsq_reset_state);
        tq.delete();
        rec = 1'b1;
        req_end_state = e;
        req_valid = 1'b1;
        @(negedge core_clk);
        req_valid = 1'b0;
        repeat (2) @(negedge core_clk);
        for (i = 0; i < 200 && busy !== 1'b0; i++) @(negedge core_clk);
        if (i == 200) timeout();
        rec = 1'b0;
        off = tq.size() - len;
        chk(4'(off >= 0), 4'h1);
        for (i = 0; i < tq.size() && off >= 0; i++) chk(4'(tq[i]), 4'(i >= off ? bits[len-1-i+off] : stay));
        lfsr = lfsr_next(lfsr);
        req_end_state = tsq_state_e'(lfsr[3:0]);
        repeat (16 + lfsr[7:4]) @(negedge core_clk);
        chk(tgt_state, e);
        chk(current_tap_state_field, tgt_state);
        chk(4'(busy), 4'h0);
    endtask

    // Buffer stall while in shift state s, then release back to s
    task stall(input logic g, input tsq_state_e e, input tsq_state_e s);
        int i;
        gated_mode = g;
        buf_stall = 1'b1;
        for (i = 0; i < 200 && tgt_state !== e; i++) @(negedge core_clk);
        if (i == 200) timeout();
        repeat (24) @(negedge core_clk);
        chk(tgt_state, e);
        chk(4'(tms), 4'h0);
        buf_stall = 1'b0;
        for (i = 0; i < 200 && tgt_state !== s; i++) @(negedge core_clk);
        if (i == 200) timeout();
        chk(tgt_state, s);
        gated_mode = lfsr[0];
    endtask

    initial begin
        repeat (3) @(negedge core_clk);
        sys_rst = 1'b0;
        repeat (4) @(negedge core_clk);
        chk(current_tap_state_field, tsq_reset_state);
        run(tsq_reset_state, 0, 7'h00);
        run(tsq_idle_state, 1, 7'h00);
        run(tsq_idle_state, 0, 7'h00);
        run(tsq_shift_dr_state, 3, 7'h04);
        run(tsq_pause_dr_state, 2, 7'h02);
        run(tsq_pause_dr_state, 6, 7'h3A);
        run(tsq_shift_dr_state, 2, 7'h02);
        stall(1'b0, tsq_pause_dr_state, tsq_shift_dr_state);
        stall(1'b1, tsq_shift_dr_state, tsq_shift_dr_state);
        run(tsq_pause_ir_state, 7, 7'h7A);
        run(tsq_pause_ir_state, 7, 7'h7A);
        run(tsq_shift_ir_state, 2, 7'h02);
        run(tsq_pause_dr_state, 6, 7'h3A);
        run(tsq_shift_ir_state, 6, 7'h3C);
        stall(1'b0, tsq_pause_ir_state, tsq_shift_ir_state);
        stall(1'b1, tsq_shift_ir_state, tsq_shift_ir_state);
        run(tsq_pause_ir_state, 2, 7'h02);
        run(tsq_pause_dr_state, 6, 7'h3A);
        run(tsq_reset_state, 5, 7'h1F);
        run(tsq_pause_dr_state, 5, 7'h0A);
        run(tsq_pause_ir_state, 7, 7'h7A);
        run(tsq_idle_state, 3, 7'h06);
        run(tsq_pause_ir_state, 5, 7'h1A);
        run(tsq_shift_dr_state, 5, 7'h1C);
        run(tsq_idle_state, 3, 7'h06);
        run(tsq_pause_dr_state, 4, 7'h0A);
        run(tsq_idle_state, 3, 7'h06);
        run(tsq_shift_ir_state, 4, 7'h0C);
        run(tsq_reset_state, 5, 7'h1F);
        run(tsq_shift_dr_state, 4, 7'h04);
        run(tsq_reset_state, 5, 7'h1F);
        run(tsq_idle_state, 1, 7'h00);
        run(tsq_reset_state, 3, 7'h07);
        run(tsq_shift_ir_state, 5, 7'h0C);
        run(tsq_idle_state, 3, 7'h06);
        run(tsq_pause_ir_state, 5, 7'h1A);
        run(tsq_reset_state, 5, 7'h1F);
        final_report();
    end
endmodule
